// [text_attr_pkg.sv]
`default_nettype none
// ============================================================
// shared constants
package text_attr_pkg;
   // buffer window and page placement
   localparam logic [19:0] BUF_LO    = 20'hB0000;
   localparam logic [19:0] BUF_COLOR = 20'hB8000;
   localparam logic [19:0] BUF_MONO  = 20'hB0000;
   localparam logic [3:0]  WIN_SEG   = 4'hB;
   localparam int          PAGE_40_SH = 11;
   localparam int          PAGE_80_SH = 12;
   localparam logic [10:0] CELLS_40  = 11'h3E8;
   localparam logic [10:0] CELLS_80  = 11'h7D0;
   localparam int          WORDS     = 32768;
   localparam int          FONT_BYTES = 8192;
   // text modes
   localparam logic [1:0]  MODE_40   = 2'h0;
   localparam logic [1:0]  MODE_80   = 2'h1;
   localparam logic [1:0]  MODE_MONO = 2'h2;
   // attribute fields
   localparam int ATTR_FG    = 0;
   localparam int ATTR_FGI   = 3;
   localparam int ATTR_BG    = 4;
   localparam int ATTR_B7    = 7;
   // control register fields
   localparam int CTL_MODE   = 0;
   localparam int CTL_PAGE   = 2;
   localparam int CTL_BLINK  = 5;
   localparam int CTL_CSET   = 6;
   localparam int CTL_FONT   = 7;
   localparam int CTL_GO     = 8;
   localparam int BLINK_LOG  = 4;
   // register map
   localparam int          AXI_AW   = 8;
   localparam logic [7:0]  OFF_CTRL = 8'h00;
   localparam logic [7:0]  OFF_ROW  = 8'h04;
   localparam logic [7:0]  OFF_STAT = 8'h08;
   localparam logic [7:0]  OFF_BASE = 8'h0C;
   localparam logic [7:0]  CTRL_RST = 8'h20;
   localparam logic [4:0]  ROW_RST  = 5'h00;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_READ = 4'h2,
      S_FONT = 4'h4,
      S_OUT  = 4'h8
   } fetch_state_t;
endpackage : text_attr_pkg
`default_nettype wire

// [attr_decode.sv]
`default_nettype none
// ============================================================
// attribute byte decode
module attr_decode
   import text_attr_pkg::*;
(
   // attribute, mode selects and blink phase in
   input  wire logic [7:0] attr,
   input  wire logic       blink_sel,
   input  wire logic       cset_sel,
   input  wire logic       blink_phase,
   // decoded fields
   output logic [2:0]      fg,
   output logic            fg_int,
   output logic [2:0]      bg,
   output logic            bg_int,
   output logic            font_set,
   output logic            hide
);
   always_comb begin
      fg       = attr[ATTR_FG +: 3];
      bg       = attr[ATTR_BG +: 3];
      fg_int   = cset_sel ? 1'b0 : attr[ATTR_FGI];
      font_set = cset_sel ? attr[ATTR_FGI] : 1'b0;
      bg_int   = blink_sel ? 1'b0 : attr[ATTR_B7];
      hide     = blink_sel & attr[ATTR_B7] & blink_phase;
   end
endmodule : attr_decode
`default_nettype wire

// [text_mode_char_attr_fetch.sv]
`default_nettype none
// Operation
// - planes 2 and 3 form the odd/even pair holding font patterns
// - planes 0 and 1 appear to the host as one buffer
// - fetch walks sequential word addresses, one char/attr word each
// - char code at even byte, its attribute at the next odd byte
// - attribute: fg bgr bits 0-2, bit 3, bg bgr bits 4-6, bit 7
// - bit 7 means blink or background intensity, selectable
// - bit 3 means foreground intensity or font set select
// - 40x25 buffer at B8000, 8 pages 800h apart
// - 80x25 at B8000, mono at B0000, 8 pages 4KB apart
module text_mode_char_attr_fetch
   import text_attr_pkg::*;
(
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   // axi4-lite slave
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [text_attr_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [text_attr_pkg::AXI_AW-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // host buffer port
   input  wire logic              host_we,
   input  wire logic              host_re,
   input  wire logic [19:0]       host_addr,
   input  wire logic [7:0]        host_wdata,
   output logic [7:0]             host_rdata,
   output logic                   host_rvalid,
   // cell stream
   output logic                   cell_valid,
   input  wire logic              cell_ready,
   output logic [7:0]             cell_char,
   output logic [7:0]             cell_attr,
   output logic [7:0]             cell_font,
   output logic [2:0]             cell_fg,
   output logic                   cell_fg_int,
   output logic [2:0]             cell_bg,
   output logic                   cell_bg_int,
   output logic                   cell_hide,
   output logic                   cell_last
);
   // ============================================================
   // storage
   logic [7:0] plane0 [WORDS];
   logic [7:0] plane1 [WORDS];
   logic [7:0] plane2 [FONT_BYTES];
   logic [7:0] plane3 [FONT_BYTES];

   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [4:0]  row_r, row_nxt;
   logic        aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
   logic [7:0]  awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic [3:0]  ws_r, ws_nxt;
   logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
   logic        bv_r, bv_nxt, arrdy_r, arrdy_nxt, rv_r, rv_nxt;
   logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
   logic [31:0] rd_r, rd_nxt;
   // start is delayed a cycle so the page base sees the config written with it
   logic        go, go_r;
   logic        do_wr;

   fetch_state_t st_r, st_nxt;
   logic [14:0] widx_r, widx_nxt;
   logic [10:0] cell_r, cell_nxt;
   logic [BLINK_LOG-1:0] frm_r, frm_nxt;
   logic [7:0]  ch_r, ch_nxt, at_r, at_nxt;
   logic [7:0]  o_ch_nxt, o_at_nxt, o_fn_nxt;
   logic        o_v_nxt, o_last_nxt;
   logic [2:0]  o_fg_nxt, o_bg_nxt;
   logic        o_fgi_nxt, o_bgi_nxt, o_hide_nxt;

   logic [1:0]  mode;
   logic [2:0]  page;
   logic [19:0] base;
   logic [10:0] cells;
   logic [15:0] hoff;
   logic        hwin;
   logic        p0_we, p1_we, p2_we, p3_we;
   logic [7:0]  h_rd_nxt;
   logic        h_rv_nxt;
   logic [2:0]  d_fg, d_bg;
   logic        d_fgi, d_bgi, d_set, d_hide;
   logic [13:0] fidx;

   assign mode = ctrl_r[CTL_MODE +: 2];
   assign page = ctrl_r[CTL_PAGE +: 3];

   // ============================================================
   // page base
   always_comb begin
      if (mode == MODE_40) begin
         base  = BUF_COLOR + {6'h0, page, 11'h0};
         cells = CELLS_40;
      end else if (mode == MODE_MONO) begin
         base  = BUF_MONO + {5'h0, page, 12'h0};
         cells = CELLS_80;
      end else begin
         base  = BUF_COLOR + {5'h0, page, 12'h0};
         cells = CELLS_80;
      end
   end

   // ============================================================
   // register bus
   always_comb begin
      aw_h_nxt = aw_h_r;
      w_h_nxt  = w_h_r;
      awa_nxt  = awa_r;
      wd_nxt   = wd_r;
      ws_nxt   = ws_r;
      ctrl_nxt = ctrl_r;
      row_nxt  = row_r;
      br_nxt   = br_r;
      bv_nxt   = bv_r & ~s_axi_bready;
      go       = 1'b0;
      do_wr    = aw_h_r & w_h_r & ~bv_r;
      if (s_axi_awvalid && awrdy_r) begin
         aw_h_nxt = 1'b1;
         awa_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wrdy_r) begin
         w_h_nxt = 1'b1;
         wd_nxt  = s_axi_wdata;
         ws_nxt  = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_h_nxt = 1'b0;
         w_h_nxt  = 1'b0;
         bv_nxt   = 1'b1;
         br_nxt   = RESP_OK;
         if (awa_r == OFF_CTRL) begin
            if (ws_r[0]) ctrl_nxt = wd_r[7:0];
            go = ws_r[1] & wd_r[CTL_GO];
         end else if (awa_r == OFF_ROW) begin
            if (ws_r[0]) row_nxt = wd_r[4:0];
         end else if (awa_r != OFF_STAT && awa_r != OFF_BASE) begin
            br_nxt = RESP_ERR;
         end
      end
      awrdy_nxt = ~aw_h_nxt & ~bv_nxt;
      wrdy_nxt  = ~w_h_nxt & ~bv_nxt;
      rv_nxt    = rv_r & ~s_axi_rready;
      rd_nxt    = rd_r;
      rr_nxt    = rr_r;
      if (s_axi_arvalid && arrdy_r) begin
         rv_nxt = 1'b1;
         rr_nxt = RESP_OK;
         if (s_axi_araddr == OFF_CTRL) begin
            rd_nxt = {24'h0, ctrl_r};
         end else if (s_axi_araddr == OFF_ROW) begin
            rd_nxt = {27'h0, row_r};
         end else if (s_axi_araddr == OFF_STAT) begin
            rd_nxt = {11'h0, frm_r, ~st_r[0], 5'h0, cell_r};
         end else if (s_axi_araddr == OFF_BASE) begin
            rd_nxt = {12'h0, base};
         end else begin
            rd_nxt = 32'h0;
            rr_nxt = RESP_ERR;
         end
      end
      arrdy_nxt = ~rv_nxt;
   end

   // ============================================================
   // host buffer access
   always_comb begin
      hoff  = host_addr[15:0] - BUF_LO[15:0];
      hwin  = host_addr[19:16] == WIN_SEG;
      p0_we = host_we & hwin & ~ctrl_r[CTL_FONT] & ~hoff[0];
      p1_we = host_we & hwin & ~ctrl_r[CTL_FONT] & hoff[0];
      p2_we = host_we & hwin & ctrl_r[CTL_FONT] & ~hoff[0];
      p3_we = host_we & hwin & ctrl_r[CTL_FONT] & hoff[0];
      h_rv_nxt = host_re & hwin;
      if (!hwin) begin
         h_rd_nxt = 8'h00;
      end else if (ctrl_r[CTL_FONT]) begin
         h_rd_nxt = hoff[0] ? plane3[hoff[13:1]] : plane2[hoff[13:1]];
      end else begin
         h_rd_nxt = hoff[0] ? plane1[hoff[15:1]] : plane0[hoff[15:1]];
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         if (p0_we) plane0[hoff[15:1]] <= host_wdata;
         if (p1_we) plane1[hoff[15:1]] <= host_wdata;
         if (p2_we) plane2[hoff[13:1]] <= host_wdata;
         if (p3_we) plane3[hoff[13:1]] <= host_wdata;
      end
   end

   // ============================================================
   // fetch engine
   attr_decode u_dec (
      .attr        (at_r),
      .blink_sel   (ctrl_r[CTL_BLINK]),
      .cset_sel    (ctrl_r[CTL_CSET]),
      .blink_phase (frm_r[BLINK_LOG-1]),
      .fg          (d_fg),
      .fg_int      (d_fgi),
      .bg          (d_bg),
      .bg_int      (d_bgi),
      .font_set    (d_set),
      .hide        (d_hide)
   );

   assign fidx = {d_set, ch_r, row_r};

   always_comb begin
      st_nxt     = st_r;
      widx_nxt   = widx_r;
      cell_nxt   = cell_r;
      frm_nxt    = frm_r;
      ch_nxt     = ch_r;
      at_nxt     = at_r;
      o_v_nxt    = cell_valid;
      o_ch_nxt   = cell_char;
      o_at_nxt   = cell_attr;
      o_fn_nxt   = cell_font;
      o_fg_nxt   = cell_fg;
      o_bg_nxt   = cell_bg;
      o_fgi_nxt  = cell_fg_int;
      o_bgi_nxt  = cell_bg_int;
      o_hide_nxt = cell_hide;
      o_last_nxt = cell_last;
      case (st_r)
         S_IDLE: begin
            if (go_r) begin
               widx_nxt = 15'((base - BUF_LO) >> 1);
               cell_nxt = 11'h0;
               st_nxt   = S_READ;
            end
         end
         S_READ: begin
            ch_nxt = plane0[widx_r];
            at_nxt = plane1[widx_r];
            st_nxt = S_FONT;
         end
         S_FONT: begin
            o_v_nxt    = 1'b1;
            o_ch_nxt   = ch_r;
            o_at_nxt   = at_r;
            o_fn_nxt   = fidx[0] ? plane3[fidx[13:1]] : plane2[fidx[13:1]];
            o_fg_nxt   = d_fg;
            o_bg_nxt   = d_bg;
            o_fgi_nxt  = d_fgi;
            o_bgi_nxt  = d_bgi;
            o_hide_nxt = d_hide;
            o_last_nxt = cell_r == cells - 11'h1;
            st_nxt     = S_OUT;
         end
         S_OUT: begin
            if (cell_ready) begin
               o_v_nxt = 1'b0;
               if (cell_last) begin
                  frm_nxt = frm_r + 1'b1;
                  st_nxt  = S_IDLE;
               end else begin
                  widx_nxt = widx_r + 15'h1;
                  cell_nxt = cell_r + 11'h1;
                  st_nxt   = S_READ;
               end
            end
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // ============================================================
   // state registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RST;
         row_r  <= ROW_RST;
         aw_h_r <= 1'b0;
         w_h_r  <= 1'b0;
         awa_r  <= 8'h00;
         wd_r   <= 32'h0;
         ws_r   <= 4'h0;
         awrdy_r <= 1'b1;
         wrdy_r <= 1'b1;
         bv_r   <= 1'b0;
         br_r   <= RESP_OK;
         arrdy_r <= 1'b1;
         rv_r   <= 1'b0;
         rr_r   <= RESP_OK;
         rd_r   <= 32'h0;
         host_rdata  <= 8'h00;
         host_rvalid <= 1'b0;
         st_r   <= S_IDLE;
         go_r   <= 1'b0;
         widx_r <= 15'h0;
         cell_r <= 11'h0;
         frm_r  <= '0;
         ch_r   <= 8'h00;
         at_r   <= 8'h00;
         cell_valid  <= 1'b0;
         cell_char   <= 8'h00;
         cell_attr   <= 8'h00;
         cell_font   <= 8'h00;
         cell_fg     <= 3'h0;
         cell_bg     <= 3'h0;
         cell_fg_int <= 1'b0;
         cell_bg_int <= 1'b0;
         cell_hide   <= 1'b0;
         cell_last   <= 1'b0;
      end else if (ce) begin
         ctrl_r <= ctrl_nxt;
         row_r  <= row_nxt;
         aw_h_r <= aw_h_nxt;
         w_h_r  <= w_h_nxt;
         awa_r  <= awa_nxt;
         wd_r   <= wd_nxt;
         ws_r   <= ws_nxt;
         awrdy_r <= awrdy_nxt;
         wrdy_r <= wrdy_nxt;
         bv_r   <= bv_nxt;
         br_r   <= br_nxt;
         arrdy_r <= arrdy_nxt;
         rv_r   <= rv_nxt;
         rr_r   <= rr_nxt;
         rd_r   <= rd_nxt;
         host_rdata  <= h_rd_nxt;
         host_rvalid <= h_rv_nxt;
         st_r   <= st_nxt;
         go_r   <= go;
         widx_r <= widx_nxt;
         cell_r <= cell_nxt;
         frm_r  <= frm_nxt;
         ch_r   <= ch_nxt;
         at_r   <= at_nxt;
         cell_valid  <= o_v_nxt;
         cell_char   <= o_ch_nxt;
         cell_attr   <= o_at_nxt;
         cell_font   <= o_fn_nxt;
         cell_fg     <= o_fg_nxt;
         cell_bg     <= o_bg_nxt;
         cell_fg_int <= o_fgi_nxt;
         cell_bg_int <= o_bgi_nxt;
         cell_hide   <= o_hide_nxt;
         cell_last   <= o_last_nxt;
      end
   end

   assign s_axi_awready = awrdy_r;
   assign s_axi_wready  = wrdy_r;
   assign s_axi_bvalid  = bv_r;
   assign s_axi_bresp   = br_r;
   assign s_axi_arready = arrdy_r;
   assign s_axi_rvalid  = rv_r;
   assign s_axi_rdata   = rd_r;
   assign s_axi_rresp   = rr_r;

   // ============================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_start_base;
      st_r == S_IDLE && go_r && ce |=> widx_r == 15'(($past(base) - BUF_LO) >> 1);
   endproperty
   a_start_base: assert property (p_start_base) else $error("bad start word");

   property p_page40;
      mode == MODE_40 |-> base == BUF_COLOR + {6'h0, page, 11'h0};
   endproperty
   a_page40: assert property (p_page40) else $error("bad 40 col base");

   property p_mono;
      mode == MODE_MONO |-> base[19:15] == BUF_MONO[19:15] && base[11:0] == 12'h0;
   endproperty
   a_mono: assert property (p_mono) else $error("bad mono base");

   property p_step;
      st_r == S_OUT && cell_ready && !cell_last && ce
         |=> st_r == S_READ && widx_r == $past(widx_r) + 15'h1;
   endproperty
   a_step: assert property (p_step) else $error("fetch not sequential");

   property p_word;
      st_r == S_READ && ce |=> ch_r == plane0[$past(widx_r)] && at_r == plane1[$past(widx_r)];
   endproperty
   a_word: assert property (p_word) else $error("char/attr word mismatch");

   property p_fields;
      cell_valid |-> cell_fg == cell_attr[2:0] && cell_bg == cell_attr[6:4];
   endproperty
   a_fields: assert property (p_fields) else $error("colour fields wrong");

   property p_bit7;
      cell_valid && ctrl_r[CTL_BLINK] && $stable(ctrl_r)
         |-> !cell_bg_int && (cell_hide -> cell_attr[7]);
   endproperty
   a_bit7: assert property (p_bit7) else $error("bit 7 misused");

   property p_bit3;
      cell_valid && !ctrl_r[CTL_CSET] && $stable(ctrl_r) |-> cell_fg_int == cell_attr[3];
   endproperty
   a_bit3: assert property (p_bit3) else $error("bit 3 misused");

   property p_steer;
      host_we && hwin && !ctrl_r[CTL_FONT] |-> p0_we != p1_we && p0_we == ~host_addr[0];
   endproperty
   a_steer: assert property (p_steer) else $error("byte lane steering wrong");

   property p_font;
      host_we && hwin |-> (p2_we | p3_we) == ctrl_r[CTL_FONT];
   endproperty
   a_font: assert property (p_font) else $error("font plane write wrong");

   property p_hold;
      cell_valid && !cell_ready |=> cell_valid && $stable(cell_char) && $stable(cell_attr);
   endproperty
   a_hold: assert property (p_hold) else $error("cell dropped");

   property p_bresp;
      aw_h_r && w_h_r && !bv_r && ce |=> bv_r;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response late");

   c_frame: cover property (cell_valid && cell_ready && cell_last);
   c_wr:    cover property (s_axi_bvalid && s_axi_bready);
   c_blink: cover property (cell_valid && cell_hide);
   c_set:   cover property (st_r == S_FONT && d_set);
endmodule : text_mode_char_attr_fetch
`default_nettype wire

// [host_buf_model.sv]
`default_nettype none
// ============================================================
// host processor filling and reading the display buffer
module host_buf_model (
   // clock
   input  wire logic       clk,
   // buffer port
   output logic            host_we,
   output logic            host_re,
   output logic [19:0]     host_addr,
   output logic [7:0]      host_wdata,
   input  wire logic [7:0] host_rdata,
   input  wire logic       host_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   // copy of every byte written, indexed by offset in the window
   logic [7:0] img [0:65535];

   initial begin
      host_we = 1'b0;
      host_re = 1'b0;
      host_addr = 20'h00000;
      host_wdata = 8'h00;
   end

   // one byte per cycle: char at even address, attribute at next odd
   task automatic fill(input logic [19:0] base, input int n);
      logic [19:0] a;
      logic [7:0]  d;
      d = 8'h00;
      for (int i = 0; i < n; i++) begin
         a = base + 20'(i);
         d = 8'($urandom);
         img[a[15:0]] = d;
         host_we <= 1'b1;
         host_addr <= a;
         host_wdata <= d;
         @(posedge clk);
      end
      host_we <= 1'b0;
      // released data line must not keep showing the last byte
      host_wdata <= ~d;
   endtask : fill

   task automatic read(input logic [19:0] a, output logic [7:0] d, output logic v);
      host_re <= 1'b1;
      host_addr <= a;
      @(posedge clk);
      host_re <= 1'b0;
      @(posedge clk);
      d = host_rdata;
      v = host_rvalid;
   endtask : read
endmodule : host_buf_model
`default_nettype wire

// [text_mode_char_attr_fetch_test.sv]
`default_nettype none
module text_mode_char_attr_fetch_test
   import text_attr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rstn, ce;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic host_we, host_re, host_rvalid, hv;
   logic [19:0] host_addr, ha;
   logic [7:0] host_wdata, host_rdata, hd;
   logic [4:0] row_v;
   logic cell_valid, cell_ready, cell_fg_int, cell_bg_int, cell_hide, cell_last;
   logic [7:0] cell_char, cell_attr, cell_font;
   logic [2:0] cell_fg, cell_bg;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int frames = 0;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   text_mode_char_attr_fetch dut_u (.clk(clk), .rstn(rstn), .ce(ce),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .host_we(host_we), .host_re(host_re), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .cell_valid(cell_valid),
      .cell_ready(cell_ready), .cell_char(cell_char), .cell_attr(cell_attr),
      .cell_font(cell_font), .cell_fg(cell_fg), .cell_fg_int(cell_fg_int), .cell_bg(cell_bg),
      .cell_bg_int(cell_bg_int), .cell_hide(cell_hide), .cell_last(cell_last));

   host_buf_model hm_u (.clk(clk), .host_we(host_we), .host_re(host_re),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid));

   // ============================================================
   // checking and closing
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         finish_test();
      end
   end

   // ============================================================
   // register bus master
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge clk);
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
      end while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clk);
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   // ============================================================
   // expectations
   function automatic logic [19:0] base_of(input logic [1:0] m, input logic [2:0] p);
      if (m == MODE_40) return BUF_COLOR + (20'(p) << 11);
      if (m == MODE_MONO) return BUF_MONO + (20'(p) << 12);
      return BUF_COLOR + (20'(p) << 12);
   endfunction : base_of

   task automatic run_frame(input logic [1:0] m, input logic [2:0] p, input logic blink,
                            input logic cset, input int n);
      logic [19:0] b;
      logic [15:0] o;
      logic [7:0]  ch;
      logic [7:0]  at;
      int          got;
      b = base_of(m, p);
      got = 0;
      hm_u.fill(b, 2 * n);
      axi_wr(OFF_CTRL, {23'h0, 1'b1, 1'b0, cset, blink, p, m}, resp);
      axi_rd(OFF_STAT, rd, resp);
      check("busy", {31'h0, rd[16]}, 32'h1);
      while (got < n) begin
         @(posedge clk);
         if (ce && cell_valid && cell_ready) begin
            o = b[15:0] + 16'(2 * got);
            ch = hm_u.img[o];
            at = hm_u.img[o + 16'h1];
            check("cell_char", {24'h0, cell_char}, {24'h0, ch});
            check("cell_attr", {24'h0, cell_attr}, {24'h0, at});
            o = {2'b00, cset & at[3], ch, row_v};
            check("cell_font", {24'h0, cell_font}, {24'h0, hm_u.img[o]});
            check("cell_fg", {29'h0, cell_fg}, {29'h0, at[2:0]});
            check("cell_bg", {29'h0, cell_bg}, {29'h0, at[6:4]});
            check("cell_fg_int", {31'h0, cell_fg_int}, {31'h0, !cset && at[3]});
            check("cell_bg_int", {31'h0, cell_bg_int}, {31'h0, !blink && at[7]});
            check("cell_hide", {31'h0, cell_hide}, {31'h0, blink & at[7] & frames[3]});
            check("cell_last", {31'h0, cell_last}, 32'(got == n - 1));
            got++;
         end
         cell_ready <= (got < n) && ($urandom_range(3) != 0);
         ce <= (got >= n) || ($urandom_range(7) != 0);
      end
      frames++;
      repeat (4) @(posedge clk);
      axi_rd(OFF_STAT, rd, resp);
      check("frame_count", {28'h0, rd[20:17]}, 32'(frames));
      check("busy_end", {31'h0, rd[16]}, 32'h0);
   endtask : run_frame

   // ============================================================
   // main sequence
   initial begin
      void'($urandom(77));
      rstn = 1'b0;
      ce = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      cell_ready = 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      axi_rd(OFF_CTRL, rd, resp);
      check("ctrl_reset", rd, {24'h0, CTRL_RST});
      check("ctrl_rresp", {30'h0, resp}, {30'h0, RESP_OK});
      axi_rd(OFF_ROW, rd, resp);
      check("row_reset", rd, {27'h0, ROW_RST});
      axi_rd(8'h10, rd, resp);
      check("unmapped_rdata", rd, 32'h0);
      check("unmapped_rresp", {30'h0, resp}, {30'h0, RESP_ERR});
      axi_wr(8'h14, 32'hFFFFFFFF, resp);
      check("unmapped_bresp", {30'h0, resp}, {30'h0, RESP_ERR});
      row_v = 5'($urandom_range(31));
      axi_wr(OFF_ROW, {27'h0, row_v}, resp);
      axi_rd(OFF_ROW, rd, resp);
      check("row_value", rd, {27'h0, row_v});
      // font planes take the low 16 KB of the window while font load is set
      axi_wr(OFF_CTRL, 32'hA0, resp);
      hm_u.fill(BUF_LO, 16384);
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 8; p++) begin
            axi_wr(OFF_CTRL, 32'(m + 4 * p) | 32'h20, resp);
            axi_rd(OFF_BASE, rd, resp);
            check("page_base", rd, {12'h0, base_of(2'(m), 3'(p))});
         end
      end
      hm_u.fill(BUF_COLOR, 64);
      for (int i = 0; i < 8; i++) begin
         ha = BUF_COLOR + 20'($urandom_range(63));
         hm_u.read(ha, hd, hv);
         check("host_rvalid", {31'h0, hv}, 32'h1);
         check("host_rdata", {24'h0, hd}, {24'h0, hm_u.img[ha[15:0]]});
      end
      hm_u.read(20'hA0000, hd, hv);
      check("host_out_window", {31'h0, hv}, 32'h0);
      run_frame(MODE_40, 3'h3, 1'b1, 1'b0, 1000);
      // mono page kept clear of the font area in the host image
      run_frame(MODE_MONO, 3'h4, 1'b0, 1'b1, 2000);
      finish_test();
   end
endmodule : text_mode_char_attr_fetch_test
`default_nettype wire
